// ==== verilog/scf_pkg.sv ====
// Constants, register map and carrier types of the CPU state and
// interrupt flag block.
// Assumes one core clock per machine cycle and an APB master with 32-bit data.
package scf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_STAT   = 8'h00;
  localparam logic [7:0] OFF_STK    = 8'h04;
  localparam logic [7:0] OFF_PTRL   = 8'h08;
  localparam logic [7:0] OFF_PTRH   = 8'h0c;
  localparam logic [7:0] OFF_TMRC   = 8'h10;
  localparam logic [7:0] OFF_EN     = 8'h14;
  localparam logic [7:0] OFF_ACC    = 8'h18;
  localparam logic [7:0] OFF_SERIAL = 8'h1c;
  localparam logic [7:0] OFF_POLL   = 8'h20;

  // ==========================================================
  // Reset values
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STK_RESET  = 8'h07;
  localparam logic [7:0] PTR_RESET  = 8'h00;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] EN_RESET   = 8'h00;

  // ==========================================================
  // Status word fields
  localparam int ST_CARRY    = 7;
  localparam int ST_HALF     = 6;
  localparam int ST_USER0    = 5;
  localparam int ST_BANK_HI  = 4;
  localparam int ST_BANK_LO  = 3;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_PARITY   = 0;

  // ==========================================================
  // Timer control fields
  localparam int TC_MODE_A  = 0;
  localparam int TC_FLAG_A  = 1;
  localparam int TC_MODE_B  = 2;
  localparam int TC_FLAG_B  = 3;
  localparam int TC_TFLAG_A = 5;
  localparam int TC_TFLAG_B = 7;

  // ==========================================================
  // Interrupt sources, in enable bit order
  localparam int SRC_N      = 5;
  localparam int SRC_EXT_A  = 0;
  localparam int SRC_TMR_A  = 1;
  localparam int SRC_EXT_B  = 2;
  localparam int SRC_TMR_B  = 3;
  localparam int SRC_SERIAL = 4;
  localparam int EN_GLOBAL  = 7;

  // ==========================================================
  // Bus slave states and carriers
  typedef enum logic [0:0] {APB_IDLE, APB_ANSWER} scf_apb_st_t;

  typedef struct packed {
    logic       update;
    logic       subtract;
    logic       carryIn;
    logic [7:0] opA;
    logic [7:0] opB;
  } scf_alu_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] source;
  } scf_vec_t;

  typedef struct packed {
    logic push;
    logic pop;
  } scf_stack_t;

endpackage

// ==== verilog/scf_ext_detect.sv ====
// One external request pin detector with its request flag, sticky in edge mode and following the pin in level mode.
// Assumes the pin is already synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module scf_ext_detect
  import scf_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pin and mode
  input  wire logic pinLevel,
  input  wire logic edgeMode,
  // Clear and software access
  input  wire logic vecClear,
  input  wire logic swWrite,
  input  wire logic swValue,
  // Flag out
  output logic      requestFlag
);

  logic prevPin;
  logic next_prevPin;
  logic next_requestFlag;

  // ==========================================================
  // Edge or level request
  always_comb begin
    next_prevPin     = pinLevel;
    next_requestFlag = requestFlag;
    if (edgeMode) begin
      if (swWrite) begin
        next_requestFlag = swValue;
      end
      if (vecClear) begin
        next_requestFlag = 1'b0;
      end
      // event sets flag; set beats any clear
      if (prevPin && !pinLevel) begin
        next_requestFlag = 1'b1;
      end
    end else begin
      // pin drives flag; level source holds it low
      next_requestFlag = !pinLevel;
    end
  end

  // Idle pin is high, so no false edge after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevPin     <= 1'b1;
      requestFlag <= 1'b0;
    end else begin
      prevPin     <= next_prevPin;
      requestFlag <= next_requestFlag;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/scf_cpu_state.sv ====
// CPU status word, stack pointer, data pointer and interrupt flag block.
// Assumes the execution unit drives its strobes for one core_clk each,
// and an APB master that holds its request until pready.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module scf_cpu_state
  import scf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Execution unit
  input  wire scf_alu_t          aluReq,
  input  wire logic              accWrite,
  input  wire logic [7:0]        accData,
  input  wire scf_stack_t        stackReq,
  input  wire logic              ptrLoadWord,
  input  wire logic [15:0]       ptrWord,
  input  wire scf_vec_t          vecAck,
  // Event sources
  input  wire logic [1:0]        extPin,
  input  wire logic [1:0]        timerRollover,
  input  wire logic              serialRxDone,
  input  wire logic              serialRxError,
  input  wire logic              serialTxDone,
  // State out
  output logic [7:0]             statusWord,
  output logic [7:0]             stackTop,
  output logic [15:0]            dataPointerPair,
  output logic [7:0]             bankBase,
  output logic [SRC_N-1:0]       irqPoll
);

  // ==========================================================
  // State
  scf_apb_st_t      apbState;
  scf_apb_st_t      next_apbState;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic [7:0]       accumulator;
  logic [7:0]       next_accumulator;
  logic [7:0]       next_statusWord;
  logic [7:0]       next_stackTop;
  logic [7:0]       dataPointerLowByte;
  logic [7:0]       next_dataPointerLowByte;
  logic [7:0]       dataPointerHighByte;
  logic [7:0]       next_dataPointerHighByte;
  logic [1:0]       extEdgeMode;
  logic [1:0]       next_extEdgeMode;
  logic [1:0]       timerRolloverFlag;
  logic [1:0]       next_timerRolloverFlag;
  logic             serialFlag;
  logic             next_serialFlag;
  logic [7:0]       irqEnable;
  logic [7:0]       next_irqEnable;
  logic [SRC_N-1:0] sampledFlags;
  logic [SRC_N-1:0] next_sampledFlags;
  logic [SRC_N-1:0] next_irqPoll;
  logic [15:0]      next_dataPointerPair;
  logic [7:0]       next_bankBase;
  logic [1:0]       extRequestFlag;
  logic [1:0]       extVecClear;
  logic             writeCommit;
  logic             tmrcWrite;
  logic [7:0]       wrByte;
  logic [7:0]       tmrcRead;
  logic [SRC_N-1:0] allFlags;
  logic [4:0]       lowNibble;
  logic [8:0]       fullByte;
  logic [7:0]       aluResult;
  logic             aluOverflow;

  // ==========================================================
  // Write commit: only at the edge that samples pready high
  assign writeCommit = (apbState == APB_ANSWER) && psel && penable && pwrite && pstrb[0];
  assign wrByte      = pwdata[7:0];
  assign tmrcWrite   = writeCommit && (paddr[7:0] == OFF_TMRC);
  assign tmrcRead    = {timerRolloverFlag[1], 1'b0, timerRolloverFlag[0], 1'b0,
                        extRequestFlag[1], extEdgeMode[1], extRequestFlag[0], extEdgeMode[0]};

  // ==========================================================
  // Bus slave: one wait state, registered answer
  always_comb begin
    next_apbState = apbState;
    next_prdata   = prdata;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    case (apbState)
      APB_IDLE: begin
        if (psel && penable) begin
          next_apbState = APB_ANSWER;
          next_pready   = 1'b1;
          next_prdata   = 32'h0000_0000;
          if (paddr[7:0] == OFF_STAT) begin
            next_prdata[7:0] = statusWord;
          end else if (paddr[7:0] == OFF_STK) begin
            next_prdata[7:0] = stackTop;
          end else if (paddr[7:0] == OFF_PTRL) begin
            next_prdata[7:0] = dataPointerLowByte;
          end else if (paddr[7:0] == OFF_PTRH) begin
            next_prdata[7:0] = dataPointerHighByte;
          end else if (paddr[7:0] == OFF_TMRC) begin
            next_prdata[7:0] = tmrcRead;
          end else if (paddr[7:0] == OFF_EN) begin
            next_prdata[7:0] = irqEnable;
          end else if (paddr[7:0] == OFF_ACC) begin
            next_prdata[7:0] = accumulator;
          end else if (paddr[7:0] == OFF_SERIAL) begin
            next_prdata[0] = serialFlag;
          end else if (paddr[7:0] == OFF_POLL) begin
            next_prdata[SRC_N-1:0] = irqPoll;
          end else begin
            next_pslverr = 1'b1; // Unmapped address
          end
        end
      end
      APB_ANSWER: begin
        next_apbState = APB_IDLE;
      end
      default: begin
        next_apbState = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      apbState <= APB_IDLE;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      apbState <= next_apbState;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // ==========================================================
  // Arithmetic flags from the execution unit operands
  always_comb begin
    if (aluReq.subtract) begin
      lowNibble = {1'b0, aluReq.opA[3:0]} - {1'b0, aluReq.opB[3:0]} - {4'h0, aluReq.carryIn};
      fullByte  = {1'b0, aluReq.opA} - {1'b0, aluReq.opB} - {8'h00, aluReq.carryIn};
    end else begin
      lowNibble = {1'b0, aluReq.opA[3:0]} + {1'b0, aluReq.opB[3:0]} + {4'h0, aluReq.carryIn};
      fullByte  = {1'b0, aluReq.opA} + {1'b0, aluReq.opB} + {8'h00, aluReq.carryIn};
    end
    aluResult = fullByte[7:0];
    if (aluReq.subtract) begin
      aluOverflow = (aluReq.opA[7] != aluReq.opB[7]) && (aluResult[7] != aluReq.opA[7]);
    end else begin
      aluOverflow = (aluReq.opA[7] == aluReq.opB[7]) && (aluResult[7] != aluReq.opA[7]);
    end
  end

  // ==========================================================
  // Accumulator, status word, stack and data pointer
  always_comb begin
    next_accumulator         = accumulator;
    next_statusWord          = statusWord;
    next_stackTop            = stackTop;
    next_dataPointerLowByte  = dataPointerLowByte;
    next_dataPointerHighByte = dataPointerHighByte;
    // Core writes win over the bus in the same cycle
    if (writeCommit && (paddr[7:0] == OFF_ACC)) begin
      next_accumulator = wrByte;
    end
    if (accWrite) begin
      next_accumulator = accData;
    end
    if (writeCommit && (paddr[7:0] == OFF_STAT)) begin
      next_statusWord = wrByte;
    end
    if (aluReq.update) begin
      next_statusWord[ST_CARRY]    = fullByte[8];
      next_statusWord[ST_HALF]     = lowNibble[4];
      next_statusWord[ST_OVERFLOW] = aluOverflow;
    end
    next_statusWord[ST_PARITY] = ^next_accumulator;
    if (writeCommit && (paddr[7:0] == OFF_STK)) begin
      next_stackTop = wrByte;
    end
    if (stackReq.push) begin
      next_stackTop = stackTop + 8'h01;
    end else if (stackReq.pop) begin
      next_stackTop = stackTop - 8'h01;
    end
    if (writeCommit && (paddr[7:0] == OFF_PTRL)) begin
      next_dataPointerLowByte = wrByte;
    end
    if (writeCommit && (paddr[7:0] == OFF_PTRH)) begin
      next_dataPointerHighByte = wrByte;
    end
    if (ptrLoadWord) begin
      next_dataPointerLowByte  = ptrWord[7:0];
      next_dataPointerHighByte = ptrWord[15:8];
    end
    next_dataPointerPair = {next_dataPointerHighByte, next_dataPointerLowByte};
    next_bankBase = {3'h0, next_statusWord[ST_BANK_HI], next_statusWord[ST_BANK_LO], 3'h0};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator         <= ACC_RESET;
      statusWord          <= STAT_RESET;
      stackTop            <= STK_RESET;
      dataPointerLowByte  <= PTR_RESET;
      dataPointerHighByte <= PTR_RESET;
      dataPointerPair     <= {PTR_RESET, PTR_RESET};
      bankBase            <= 8'h00;
    end else begin
      accumulator         <= next_accumulator;
      statusWord          <= next_statusWord;
      stackTop            <= next_stackTop;
      dataPointerLowByte  <= next_dataPointerLowByte;
      dataPointerHighByte <= next_dataPointerHighByte;
      dataPointerPair     <= next_dataPointerPair;
      bankBase            <= next_bankBase;
    end
  end

  // ==========================================================
  // External request pins, one detector each
  assign extVecClear[0] = vecAck.valid && (vecAck.source == 3'(SRC_EXT_A));
  assign extVecClear[1] = vecAck.valid && (vecAck.source == 3'(SRC_EXT_B));

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gExt
      scf_ext_detect uDetect (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .pinLevel    (extPin[gi]),
        .edgeMode    (extEdgeMode[gi]),
        .vecClear    (extVecClear[gi]),
        .swWrite     (tmrcWrite),
        .swValue     (wrByte[2*gi+1]),
        .requestFlag (extRequestFlag[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Timer, serial and enable state, sampling and polling
  always_comb begin
    next_extEdgeMode       = extEdgeMode;
    next_timerRolloverFlag = timerRolloverFlag;
    next_serialFlag        = serialFlag;
    next_irqEnable         = irqEnable;
    if (tmrcWrite) begin
      next_extEdgeMode[0]       = wrByte[TC_MODE_A];
      next_extEdgeMode[1]       = wrByte[TC_MODE_B];
      next_timerRolloverFlag[0] = wrByte[TC_TFLAG_A];
      next_timerRolloverFlag[1] = wrByte[TC_TFLAG_B];
    end
    if (vecAck.valid && (vecAck.source == 3'(SRC_TMR_A)) && irqEnable[SRC_TMR_A]) begin
      next_timerRolloverFlag[0] = 1'b0;
    end
    if (vecAck.valid && (vecAck.source == 3'(SRC_TMR_B)) && irqEnable[SRC_TMR_B]) begin
      next_timerRolloverFlag[1] = 1'b0;
    end
    // rollover sets flag, wins over clears
    if (timerRollover[0]) begin
      next_timerRolloverFlag[0] = 1'b1;
    end
    if (timerRollover[1]) begin
      next_timerRolloverFlag[1] = 1'b1;
    end
    // Serial flag: write one to clear
    if (writeCommit && (paddr[7:0] == OFF_SERIAL) && wrByte[0]) begin
      next_serialFlag = 1'b0;
    end
    if (serialTxDone || (serialRxDone && !serialRxError)) begin
      next_serialFlag = 1'b1;
    end
    // Unused enable bits stay zero
    if (writeCommit && (paddr[7:0] == OFF_EN)) begin
      next_irqEnable = {wrByte[EN_GLOBAL], 2'b00, wrByte[SRC_N-1:0]};
    end
    allFlags[SRC_EXT_A]  = extRequestFlag[0];
    allFlags[SRC_TMR_A]  = timerRolloverFlag[0];
    allFlags[SRC_EXT_B]  = extRequestFlag[1];
    allFlags[SRC_TMR_B]  = timerRolloverFlag[1];
    allFlags[SRC_SERIAL] = serialFlag;
    next_sampledFlags = allFlags;
    next_irqPoll = sampledFlags & irqEnable[SRC_N-1:0] & {SRC_N{irqEnable[EN_GLOBAL]}};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extEdgeMode       <= 2'b00;
      timerRolloverFlag <= 2'b00;
      serialFlag        <= 1'b0;
      irqEnable         <= EN_RESET;
      sampledFlags      <= '0;
      irqPoll           <= '0;
    end else begin
      extEdgeMode       <= next_extEdgeMode;
      timerRolloverFlag <= next_timerRolloverFlag;
      serialFlag        <= next_serialFlag;
      irqEnable         <= next_irqEnable;
      sampledFlags      <= next_sampledFlags;
      irqPoll           <= next_irqPoll;
    end
  end

endmodule
`default_nettype wire

// ==== tb/scf_state_checker.sv ====
// Port-level assertions for the CPU state and interrupt flag block.
// Assumes one core clock per machine cycle; bound into scf_cpu_state.
`timescale 1ns/1ps
`default_nettype none
module scf_state_checker
  import scf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Bus and core strobes
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire scf_alu_t          aluReq,
  input wire logic              accWrite,
  input wire logic [7:0]        accData,
  input wire scf_stack_t        stackReq,
  input wire logic              ptrLoadWord,
  input wire logic [15:0]       ptrWord,
  input wire scf_vec_t          vecAck,
  input wire logic [1:0]        timerRollover,
  // State out
  input wire logic [7:0]        statusWord,
  input wire logic [7:0]        stackTop,
  input wire logic [15:0]       dataPointerPair,
  input wire logic [7:0]        bankBase,
  input wire logic [SRC_N-1:0]  irqPoll
);
  // ==========================================================
  // Helpers
  logic       busDone;
  logic [7:0] enShadow;
  logic [7:0] next_enShadow;
  logic       halfExp;
  logic       next_halfExp;
  logic [4:0] sumLow;

  // Enable shadow snooped off the bus, low nibble carry predicted
  assign busDone = psel && penable && pready && pwrite && pstrb[0];
  always_comb begin
    next_enShadow = enShadow;
    if (busDone && paddr == ADDR_W'(OFF_EN)) begin
      next_enShadow = pwdata[7:0];
    end
    sumLow = aluReq.subtract ?
      {1'b0, aluReq.opA[3:0]} - {1'b0, aluReq.opB[3:0]} - 5'(aluReq.carryIn) :
      {1'b0, aluReq.opA[3:0]} + {1'b0, aluReq.opB[3:0]} + 5'(aluReq.carryIn);
    next_halfExp = sumLow[4];
  end

  // Registered copies
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enShadow <= 8'h00;
      halfExp  <= 1'b0;
    end else begin
      enShadow <= next_enShadow;
      halfExp  <= next_halfExp;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_parity_track: assert property (
    accWrite |=> statusWord[ST_PARITY] == ^$past(accData))
    else $error("parity flag wrong after accumulator load");
  chk_parity_hold: assert property (
    !accWrite && !(busDone && paddr == ADDR_W'(OFF_ACC)) |=> $stable(statusWord[ST_PARITY]))
    else $error("parity flag moved without accumulator change");
  chk_half_carry: assert property (
    aluReq.update |=> statusWord[ST_HALF] == halfExp)
    else $error("half carry flag wrong");
  chk_bank_base: assert property (
    $stable(statusWord) |-> bankBase == {3'b000, statusWord[4:3], 3'b000})
    else $error("bank base does not match bank bits");
  chk_stack_reset: assert property (
    $rose(rst_n) |-> stackTop == 8'h07)
    else $error("stack top not 07 after reset");
  chk_push_incr: assert property (
    stackReq.push |=> stackTop == $past(stackTop) + 8'h01)
    else $error("stack top not incremented by push");
  chk_word_load: assert property (
    ptrLoadWord |=> dataPointerPair == $past(ptrWord))
    else $error("pointer word load wrong");
  chk_timer_poll: assert property (
    timerRollover[0] && enShadow[EN_GLOBAL] && enShadow[SRC_TMR_A] && !vecAck.valid
      |-> ##[2:3] irqPoll[SRC_TMR_A])
    else $error("timer request not polled in time");
  chk_global_gate: assert property (
    !enShadow[EN_GLOBAL] && $stable(enShadow) |=> irqPoll == 5'h00)
    else $error("request polled with global enable off");
endmodule

bind scf_cpu_state scf_state_checker #(.ADDR_W(ADDR_W)) u_scf_state_checker (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
  .aluReq, .accWrite, .accData, .stackReq, .ptrLoadWord, .ptrWord, .vecAck,
  .timerRollover, .statusWord, .stackTop, .dataPointerPair, .bankBase, .irqPoll);
`default_nettype wire

// ==== tb/scf_irq_partner.sv ====
// Model of the request pins, timers, serial unit and vectoring logic.
// Assumes its tasks are called just after a rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module scf_irq_partner
  import scf_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Toward the block
  output logic [1:0] extPin,
  output logic [1:0] timerRollover,
  output logic       serialRxDone,
  output logic       serialRxError,
  output logic       serialTxDone,
  output scf_vec_t   vecAck
);
  // ==========================================================
  // Idle state: pins high, no events
  initial begin
    extPin = 2'b11;
    timerRollover = 2'b00;
    {serialRxDone, serialRxError, serialTxDone} = 3'b000;
    vecAck = '0;
  end

  task automatic edge_req(input int idx);
    @(posedge core_clk);
    extPin[idx] <= 1'b0;
    @(posedge core_clk);
    extPin[idx] <= 1'b1;
  endtask

  // pin held low while service wanted
  task automatic hold_level(input int idx, input logic lvl);
    @(posedge core_clk);
    extPin[idx] <= lvl;
  endtask

  // One-cycle events; vector taken as one strobe
  task automatic pulse(input logic [1:0] tmr, input logic [2:0] ser, input scf_vec_t vec);
    @(posedge core_clk);
    timerRollover <= tmr;
    {serialRxDone, serialRxError, serialTxDone} <= ser;
    vecAck <= vec;
    @(posedge core_clk);
    timerRollover <= 2'b00;
    {serialRxDone, serialRxError, serialTxDone} <= 3'b000;
    vecAck <= '0;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the CPU state and interrupt flag block.
// Assumes the APB slave answers after one wait state, as handed over.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import scf_pkg::*;
;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0]  paddr, statusWord, stackTop, bankBase, accData, rd, acc;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  scf_alu_t    aluReq;
  scf_stack_t  stackReq;
  scf_vec_t    vecAck;
  logic        accWrite, ptrLoadWord, serialRxDone, serialRxError, serialTxDone;
  logic [15:0] ptrWord, dataPointerPair;
  logic [15:0] seed = 16'hc019;
  logic [1:0]  extPin, timerRollover;
  logic [4:0]  irqPoll;
  int          err_total = 0;
  int          n_compared = 0;

  always #2 core_clk = ~core_clk;

  scf_cpu_state #(.ADDR_W(8)) u_scf_cpu_state (.core_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .aluReq, .accWrite,
    .accData, .stackReq, .ptrLoadWord, .ptrWord, .vecAck, .extPin, .timerRollover,
    .serialRxDone, .serialRxError, .serialTxDone, .statusWord, .stackTop,
    .dataPointerPair, .bankBase, .irqPoll);
  scf_irq_partner u_scf_irq_partner (.core_clk, .extPin, .timerRollover,
    .serialRxDone, .serialRxError, .serialTxDone, .vecAck);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Low nibble carry or borrow for opA=s[7:0], opB=s[15:8]
  function automatic logic exp_half(input logic [15:0] s);
    logic [4:0] low;
    low = s[9] ? {1'b0, s[3:0]} - {1'b0, s[11:8]} - 5'(s[8])
               : {1'b0, s[3:0]} + {1'b0, s[11:8]} + 5'(s[8]);
    return low[4];
  endfunction

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; held until pready, bounded wait
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    rd = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  logic [7:0] offs [5] = '{OFF_STAT, OFF_STK, OFF_PTRL, OFF_PTRH, OFF_EN};
  logic [7:0] resv [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  initial begin
    {rst_n, psel, penable, pwrite, accWrite, ptrLoadWord} = '0;
    {paddr, pwdata, accData, ptrWord, aluReq, stackReq} = '0;
    pstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 8'h00);
      chk("reset value", rd, resv[i]);
    end
    apb(1'b0, 8'h24, 8'h00);
    chk("unmapped error", lastErr, 1'b1);
    @(posedge core_clk);
    stackReq.push <= 1'b1;
    @(posedge core_clk);
    stackReq.push <= 1'b0;
    @(posedge core_clk);
    chk("stack top", stackTop, 8'h08);
    // Random core loads, then bus writes over them
    repeat (8) begin
      seed = lfsr(seed);
      acc = seed[7:0];
      @(posedge core_clk);
      accWrite <= 1'b1;
      accData <= acc;
      aluReq <= '{1'b1, seed[9], seed[8], seed[7:0], seed[15:8]};
      ptrLoadWord <= 1'b1;
      ptrWord <= seed;
      @(posedge core_clk);
      {accWrite, aluReq.update, ptrLoadWord} <= 3'b000;
      @(posedge core_clk);
      chk("parity", statusWord[0], ^acc);
      chk("half carry", statusWord[6], exp_half(seed));
      chk("pointer word", dataPointerPair, seed);
      seed = lfsr(seed);
      apb(1'b1, OFF_PTRH, seed[15:8]);
      // Write lands at the edge the task returns on; look one edge later
      @(posedge core_clk);
      chk("pointer high", dataPointerPair[15:8], seed[15:8]);
      apb(1'b1, OFF_STAT, seed[7:0]);
      apb(1'b0, OFF_STAT, 8'h00);
      chk("parity kept", rd[0], ^acc);
      chk("bank base", bankBase, {3'b000, seed[4:3], 3'b000});
    end
    // Timer requests and vector clears
    apb(1'b1, OFF_EN, 8'h9f);
    for (int t = 0; t < 2; t++) begin
      u_scf_irq_partner.pulse(2'(1 << t), 3'b000, '0);
      repeat (3) @(posedge core_clk);
      chk("timer request", irqPoll[1 + 2 * t], 1'b1);
      u_scf_irq_partner.pulse(2'b00, 3'b000, scf_vec_t'{1'b1, 3'(1 + 2 * t)});
      repeat (3) @(posedge core_clk);
      chk("timer cleared", irqPoll[1 + 2 * t], 1'b0);
    end
    // Pins in edge mode
    apb(1'b1, OFF_TMRC, 8'h05);
    for (int p = 0; p < 2; p++) begin
      u_scf_irq_partner.edge_req(p);
      apb(1'b0, OFF_TMRC, 8'h00);
      chk("edge flag", rd[1 + 2 * p], 1'b1);
      u_scf_irq_partner.pulse(2'b00, 3'b000, scf_vec_t'{1'b1, 3'(2 * p)});
      apb(1'b0, OFF_TMRC, 8'h00);
      chk("edge flag cleared", rd[1 + 2 * p], 1'b0);
    end
    // Pin in level mode survives the vector
    apb(1'b1, OFF_TMRC, 8'h00);
    u_scf_irq_partner.hold_level(0, 1'b0);
    u_scf_irq_partner.pulse(2'b00, 3'b000, scf_vec_t'{1'b1, 3'd0});
    apb(1'b0, OFF_TMRC, 8'h00);
    chk("level flag held", rd[1], 1'b1);
    u_scf_irq_partner.hold_level(0, 1'b1);
    apb(1'b0, OFF_TMRC, 8'h00);
    chk("level flag released", rd[1], 1'b0);
    // Serial: bad frame ignored, sent frame requests
    u_scf_irq_partner.pulse(2'b00, 3'b110, '0);
    apb(1'b0, OFF_SERIAL, 8'h00);
    chk("bad frame", rd[0], 1'b0);
    u_scf_irq_partner.pulse(2'b00, 3'b001, '0);
    apb(1'b0, OFF_SERIAL, 8'h00);
    chk("frame sent", rd[0], 1'b1);
    apb(1'b1, OFF_EN, 8'h1f);
    repeat (3) @(posedge core_clk);
    chk("global off", irqPoll, 5'h00);
    apb(1'b1, OFF_EN, 8'h90);
    repeat (3) @(posedge core_clk);
    chk("serial polled", irqPoll, 5'h10);
    // Software write of one clears the serial request
    apb(1'b1, OFF_SERIAL, 8'h01);
    apb(1'b0, OFF_SERIAL, 8'h00);
    chk("serial cleared", rd[0], 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
